// [rtl/reoc_cfg.svh]
// Offsets, field positions, reset values and timing counts for the rail enable output control
`ifndef REOC_CFG_SVH
`define REOC_CFG_SVH
`define REOC_ADDR_LOW 8'h1A
`define REOC_ADDR_HIGH 8'h1B
`define REOC_LOW_MASK 8'h1E
`define REOC_VAL_RESET 16'h0000
`define REOC_RAIL_LSB 8
`define REOC_GPO_LSB 1
`define REOC_SHARED_GPO_BIT 1
`define REOC_SHARED_EN_BIT 15
`define REOC_NUM_RAILS 8
`define REOC_CLK_PERIOD_NS 8
`define REOC_RETRY_DELAY_NS 1000
`define REOC_RETRY_CYCLES ((`REOC_RETRY_DELAY_NS + `REOC_CLK_PERIOD_NS - 1) / `REOC_CLK_PERIOD_NS)
`endif

// [rtl/reoc_pkg.sv]
// Types shared by the rail enable output control modules
package reoc_pkg;
  typedef enum logic [2:0] {
    MODE_IGNORE = 3'h0,
    MODE_LOG = 3'h1,
    MODE_RETRY0 = 3'h2,
    MODE_RETRYN = 3'h3,
    MODE_CONT = 3'h4
  } reoc_mode_type;

  // Per rail alarm configuration; dep_mask [7:0] rails 1..8, [11:8] general outputs 1..4
  typedef struct packed {
    reoc_mode_type mode;
    logic [3:0] retry_limit;
    logic uv_zero;
    logic [11:0] dep_mask;
  } reoc_rail_cfg_type;

  typedef struct packed {
    logic fail;
    logic shut;
    logic deps;
    logic reassert;
    logic restart;
  } reoc_event_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DELAY = 3'b010,
    ST_OFF = 3'b100
  } reoc_state_type;
endpackage : reoc_pkg

// [rtl/reoc_rail_alarm.sv]
// Per rail undervoltage alarm handling: failure, retry, dependent shutdown, restart
`include "reoc_cfg.svh"
module reoc_rail_alarm #(
  parameter int RETRY_CYCLES = `REOC_RETRY_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input reoc_pkg::reoc_rail_cfg_type cfg, // Alarm configuration
  input wire logic enable, // Current enable bit of this rail
  input wire logic below_uv, // Rail under its undervoltage limit
  output reoc_pkg::reoc_event_type ev // One-cycle alarm events
);
  import reoc_pkg::*;
  localparam int CW = $clog2(RETRY_CYCLES + 1);
  localparam int retry_hi = RETRY_CYCLES + 2;

  reoc_state_type st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [3:0] tries_q, tries_d;
  logic armed_q, armed_d;
  logic fault;

  // Armed once the rail is enabled and in regulation; limit of zero never faults
  assign fault = armed_q && below_uv && !cfg.uv_zero && (st_q == ST_IDLE);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    tries_d = tries_q;
    armed_d = armed_q;
    ev = '0;
    if (enable && !below_uv) begin
      armed_d = 1'b1;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (fault) begin
          armed_d = 1'b0;
          unique case (cfg.mode)
            MODE_IGNORE: begin
            end
            MODE_LOG: begin
              ev.fail = 1'b1;
            end
            MODE_RETRY0: begin
              ev.fail = 1'b1;
              ev.shut = 1'b1;
              ev.restart = 1'b1;
              st_d = ST_OFF;
            end
            MODE_RETRYN: begin
              ev.fail = 1'b1;
              ev.shut = 1'b1;
              ev.deps = 1'b1;
              cnt_d = '0;
              st_d = (tries_q < cfg.retry_limit) ? ST_DELAY : ST_OFF;
            end
            MODE_CONT: begin
              ev.fail = 1'b1;
              ev.shut = 1'b1;
              ev.deps = 1'b1;
              cnt_d = '0;
              st_d = ST_DELAY;
            end
            default: begin
            end
          endcase
        end
      end
      ST_DELAY: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(RETRY_CYCLES - 1)) begin
          ev.reassert = 1'b1;
          tries_d = tries_q + 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_OFF: begin
        if (enable) begin
          tries_d = '0;
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      tries_q <= '0;
      armed_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tries_q <= tries_d;
      armed_q <= armed_d;
    end
  end

  sequence s_cont_fault;
    fault && cfg.mode == MODE_CONT;
  endsequence

  chk_uv_zero_quiet: assert property (@(posedge clk) disable iff (!resetn)
    cfg.uv_zero |-> !ev.fail && !ev.shut && !ev.deps)
    else $error("alarm raised with zero undervoltage limit");

  chk_cont_retry: assert property (@(posedge clk) disable iff (!resetn)
    s_cont_fault |-> ##[1:retry_hi] ev.reassert)
    else $error("continuous retry did not reassert in time");
endmodule : reoc_rail_alarm

// [rtl/reoc_top.sv]
// Host-writable rail enable and general output value register with alarm interaction
`include "reoc_cfg.svh"
module reoc_top #(
  parameter int RETRY_CYCLES = `REOC_RETRY_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic [7:0] reg_addr, // Command byte
  input wire logic [7:0] reg_wdata, // Write data byte
  input wire logic reg_wr, // Byte write strobe
  input wire logic reg_rd, // Byte read strobe
  output logic [7:0] reg_rdata, // Read data byte
  output logic reg_rvalid, // Read data valid pulse
  input wire logic shared_is_gpo, // Shared pin is general output one
  input reoc_pkg::reoc_rail_cfg_type rail_cfg [`REOC_NUM_RAILS], // Alarm setup per rail
  input wire logic [7:0] rail_below_uv, // Rail under its limit, bit 0 rail one
  input wire logic [7:0] fail_clear, // Clears failure flags
  output logic [6:0] rail_enable_output, // Rails one..seven enables
  output logic shared_enable_output_pin, // Rail eight enable or general output one
  output logic [4:2] general_output, // General outputs two..four
  output logic [7:0] rail_fail, // Sticky failure flags
  output logic restart_req // Restart request pulse
);
  import reoc_pkg::*;

  logic [15:0] val_q, val_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [6:0] en_pin_q, en_pin_d;
  logic shared_q, shared_d;
  logic [4:2] gpo_q, gpo_d;
  logic [7:0] fail_q, fail_d;
  logic restart_q, restart_d;
  reoc_event_type ev [`REOC_NUM_RAILS];
  logic [7:0] ev_any;
  logic wr_low, wr_high, rd_low, rd_high;

  // Dependent mask to value register bit positions
  function automatic logic [15:0] dep_bits(input logic [11:0] mask);
    dep_bits = {mask[7:0], 3'b000, mask[11:8], 1'b0};
  endfunction : dep_bits

  // Single-byte command decode
  assign wr_low = reg_wr && (reg_addr == `REOC_ADDR_LOW);
  assign wr_high = reg_wr && (reg_addr == `REOC_ADDR_HIGH);
  assign rd_low = reg_rd && (reg_addr == `REOC_ADDR_LOW);
  assign rd_high = reg_rd && (reg_addr == `REOC_ADDR_HIGH);

  genvar gi;
  generate
    for (gi = 0; gi < `REOC_NUM_RAILS; gi++) begin : g_rail
      reoc_rail_alarm #(
        .RETRY_CYCLES(RETRY_CYCLES)
      ) u_alarm (
        .clk(clk),
        .resetn(resetn),
        .cfg(rail_cfg[gi]),
        .enable(val_q[`REOC_RAIL_LSB + gi]),
        .below_uv(rail_below_uv[gi]),
        .ev(ev[gi])
      );
      assign ev_any[gi] = |ev[gi];
    end
  endgenerate

  // Output value register: host byte writes, then alarm effects on top
  always_comb begin
    val_d = val_q;
    if (wr_low) begin
      val_d[7:0] = reg_wdata & `REOC_LOW_MASK;
    end
    if (wr_high) begin
      val_d[15:8] = reg_wdata;
    end
    for (int i = 0; i < `REOC_NUM_RAILS; i++) begin
      if (ev[i].deps) begin
        val_d = val_d & ~dep_bits(rail_cfg[i].dep_mask);
      end
      if (ev[i].shut) begin
        val_d[`REOC_RAIL_LSB + i] = 1'b0;
      end
    end
    for (int i = 0; i < `REOC_NUM_RAILS; i++) begin
      if (ev[i].reassert) begin
        val_d[`REOC_RAIL_LSB + i] = 1'b1;
      end
    end
  end

  // Pins follow the next register value so they match val_q
  always_comb begin
    en_pin_d = val_d[14:8];
    gpo_d = val_d[4:2];
    shared_d = shared_is_gpo ? val_d[`REOC_SHARED_GPO_BIT] : val_d[`REOC_SHARED_EN_BIT];
  end

  // Byte read port
  always_comb begin
    rvalid_d = reg_rd;
    rdata_d = 8'h00;
    if (rd_low) begin
      rdata_d = val_q[7:0];
    end else if (rd_high) begin
      rdata_d = val_q[15:8];
    end
  end

  // Failure flags, set beats clear; restart pulse
  always_comb begin
    restart_d = 1'b0;
    for (int i = 0; i < `REOC_NUM_RAILS; i++) begin
      fail_d[i] = ev[i].fail | (fail_q[i] & ~fail_clear[i]);
      restart_d = restart_d | ev[i].restart;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      val_q <= `REOC_VAL_RESET;
      en_pin_q <= 7'h00;
      gpo_q <= 3'h0;
      shared_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      fail_q <= 8'h00;
      restart_q <= 1'b0;
    end else begin
      val_q <= val_d;
      en_pin_q <= en_pin_d;
      gpo_q <= gpo_d;
      shared_q <= shared_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      fail_q <= fail_d;
      restart_q <= restart_d;
    end
  end

  assign rail_enable_output = en_pin_q;
  assign general_output = gpo_q;
  assign shared_enable_output_pin = shared_q;
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign rail_fail = fail_q;
  assign restart_req = restart_q;

  sequence s_quiet;
    ev_any == 8'h00;
  endsequence

  sequence s_low_write;
    wr_low ##0 s_quiet;
  endsequence

  sequence s_high_write;
    wr_high ##0 s_quiet;
  endsequence

  chk_low_write_bits: assert property (@(posedge clk) disable iff (!resetn)
    s_low_write |=> val_q[4:1] == $past(reg_wdata[4:1]) ##1 general_output == $past(reg_wdata[4:2], 2))
    else $error("low byte write did not reach the general outputs");

  chk_high_write_bits: assert property (@(posedge clk) disable iff (!resetn)
    s_high_write |=> val_q[15:8] == $past(reg_wdata) && rail_enable_output == $past(reg_wdata[6:0]))
    else $error("high byte write did not reach the rail enables");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    val_q[7:5] == 3'h0 && val_q[0] == 1'b0)
    else $error("reserved low byte bits not zero");

  chk_read_high: assert property (@(posedge clk) disable iff (!resetn)
    rd_high |=> reg_rvalid && reg_rdata == $past(val_q[15:8]))
    else $error("high byte read returned wrong data");

  chk_read_low: assert property (@(posedge clk) disable iff (!resetn)
    rd_low |=> reg_rvalid && reg_rdata == $past(val_q[7:0]) && reg_rdata[7:5] == 3'h0)
    else $error("low byte read returned wrong data");

  chk_shared_pin: assert property (@(posedge clk) disable iff (!resetn)
    ##1 shared_enable_output_pin == ($past(shared_is_gpo) ? val_q[1] : val_q[15]))
    else $error("shared pin follows the wrong bit");

  chk_shut_clears: assert property (@(posedge clk) disable iff (!resetn)
    ev[0].shut && !ev[0].reassert |=> !val_q[`REOC_RAIL_LSB])
    else $error("alarm shutdown did not clear rail one enable");

  chk_reassert_sets: assert property (@(posedge clk) disable iff (!resetn)
    ev[0].reassert |=> val_q[`REOC_RAIL_LSB] ##1 rail_enable_output[0])
    else $error("retry did not reassert rail one enable");

  chk_restart_pulse: assert property (@(posedge clk) disable iff (!resetn)
    restart_d |=> restart_req ##1 !restart_req || $past(restart_d))
    else $error("restart request not raised after zero-retry shutdown");

  chk_fail_sticky: assert property (@(posedge clk) disable iff (!resetn)
    ev[0].fail |=> rail_fail[0])
    else $error("failure flag not set, or lost to a clear");

  chk_fail_clear: assert property (@(posedge clk) disable iff (!resetn)
    !ev[0].fail && fail_clear[0] |=> !rail_fail[0])
    else $error("failure flag not cleared");

  sequence s_rail1_deps;
    ev[0].deps ##0 ev_any == 8'h01;
  endsequence

  chk_deps_cleared: assert property (@(posedge clk) disable iff (!resetn)
    s_rail1_deps |=> (val_q & $past(dep_bits(rail_cfg[0].dep_mask))) == 16'h0000)
    else $error("dependent outputs left on after rail one alarm");
endmodule : reoc_top

// [dv/reoc_host_model.sv]
// Host side model issuing byte reads and writes on the register port
module reoc_host_model (
  input wire logic clk, // System clock
  output logic [7:0] reg_addr, // Command byte
  output logic [7:0] reg_wdata, // Write data byte
  output logic reg_wr, // Byte write strobe
  output logic reg_rd, // Byte read strobe
  input wire logic [7:0] reg_rdata, // Read data byte
  input wire logic reg_rvalid // Read answer pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle command and data lines show the inverse of the last value
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask : write_byte
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    data = reg_rdata;
    ok = reg_rvalid;
  endtask : read_byte
  // Read, flip the chosen bits, write back
  task automatic toggle_bits(input logic [7:0] addr, input logic [7:0] mask);
    logic [7:0] v;
    logic ok;
    read_byte(addr, v, ok);
    write_byte(addr, v ^ mask);
  endtask : toggle_bits
endmodule : reoc_host_model

// [dv/tb_reoc_top.sv]
// Self-checking bench for the rail enable output control
module tb_reoc_top;
  import reoc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic gpo;
    logic [7:0] rd;
    logic [6:0] en;
    logic sh;
    logic [2:0] go;
  } reoc_row_type;
  localparam reoc_row_type ROWS [7] = '{
    '{8'h1B, 8'hBA, 1'b0, 8'hBA, 7'h3A, 1'b1, 3'h0},
    '{8'h1A, 8'hFF, 1'b0, 8'h1E, 7'h3A, 1'b1, 3'h7},
    '{8'h1A, 8'h02, 1'b1, 8'h02, 7'h3A, 1'b1, 3'h0},
    '{8'h1B, 8'h55, 1'b1, 8'h55, 7'h55, 1'b1, 3'h0},
    '{8'h1A, 8'hE1, 1'b1, 8'h00, 7'h55, 1'b0, 3'h0},
    '{8'h1B, 8'h80, 1'b0, 8'h80, 7'h00, 1'b1, 3'h0},
    '{8'h1C, 8'hFF, 1'b0, 8'h00, 7'h00, 1'b1, 3'h0}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, shared_is_gpo, shared_enable_output_pin, restart_req;
  reoc_rail_cfg_type rail_cfg [8];
  logic [7:0] rail_below_uv, fail_clear, rail_fail;
  logic [6:0] rail_enable_output;
  logic [4:2] general_output;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_restart = 0;
  always #4 clk = ~clk;
  reoc_host_model u_reoc_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  reoc_top #(.RETRY_CYCLES(4)) u_reoc_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .shared_is_gpo(shared_is_gpo), .rail_cfg(rail_cfg), .rail_below_uv(rail_below_uv), .fail_clear(fail_clear),
    .rail_enable_output(rail_enable_output), .shared_enable_output_pin(shared_enable_output_pin),
    .general_output(general_output), .rail_fail(rail_fail), .restart_req(restart_req));
  always @(posedge clk) begin
    cycles++;
    if (restart_req === 1'b1) n_restart++;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_reoc_host_model.write_byte(a, d);
    @(negedge clk);
  endtask : wr
  initial begin
    logic [7:0] v;
    logic ok;
    int n;
    shared_is_gpo = 1'b0;
    rail_below_uv = 8'h00;
    fail_clear = 8'h00;
    foreach (rail_cfg[i]) rail_cfg[i] = '{MODE_IGNORE, 4'h0, 1'b0, 12'h000};
    repeat (5) @(negedge clk);
    chk("pins in reset", 8'h00, {rail_fail[0], rail_enable_output});
    resetn = 1'b1;
    for (int i = 0; i < 7; i++) begin
      shared_is_gpo = ROWS[i].gpo;
      wr(ROWS[i].addr, ROWS[i].wdata);
      u_reoc_host_model.read_byte(ROWS[i].addr, v, ok);
      chk("read data", ROWS[i].rd, v);
      chk("read valid", 8'h01, {7'h00, ok});
      chk("rail enables", {1'b0, ROWS[i].en}, {1'b0, rail_enable_output});
      chk("shared pin", {7'h00, ROWS[i].sh}, {7'h00, shared_enable_output_pin});
      chk("general outs", {5'h00, ROWS[i].go}, {5'h00, general_output});
    end
    $display("test rows done");
    wr(8'h1B, 8'h55);
    u_reoc_host_model.toggle_bits(8'h1B, 8'h08);
    @(negedge clk);
    chk("toggled enables", 8'h5D, {1'b0, rail_enable_output});
    $display("test toggle done");
    rail_cfg[0] = '{MODE_CONT, 4'h0, 1'b0, 12'h002};
    wr(8'h1B, 8'h03);
    wr(8'h1B, 8'h02);
    rail_below_uv = 8'h01;
    repeat (3) @(negedge clk);
    chk("fail after disable", 8'h01, rail_fail);
    chk("dependent rail off", 8'h00, {7'h00, rail_enable_output[1]});
    n = 0;
    while (rail_enable_output[0] !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("rail one reasserted", 8'h01, {7'h00, rail_enable_output[0]});
    chk("no restart on retry", 8'h00, n_restart[7:0]);
    rail_below_uv = 8'h00;
    fail_clear = 8'hFF;
    @(negedge clk);
    fail_clear = 8'h00;
    @(negedge clk);
    chk("fail cleared", 8'h00, rail_fail);
    $display("test retry done");
    rail_cfg[2] = '{MODE_RETRY0, 4'h0, 1'b0, 12'h008};
    wr(8'h1B, 8'h0C);
    wr(8'h1B, 8'h08);
    rail_below_uv = 8'h04;
    repeat (4) @(negedge clk);
    chk("restart pulses", 8'h01, n_restart[7:0]);
    chk("fail rail three", 8'h04, rail_fail);
    chk("isolated enables", 8'h08, {1'b0, rail_enable_output});
    rail_below_uv = 8'h00;
    $display("test zero retry done");
    rail_cfg[4] = '{MODE_CONT, 4'h0, 1'b1, 12'h020};
    wr(8'h1B, 8'h30);
    wr(8'h1B, 8'h20);
    rail_below_uv = 8'h10;
    repeat (10) @(negedge clk);
    chk("no flag at zero limit", 8'h00, {7'h00, rail_fail[4]});
    chk("no handling at zero limit", 8'h20, {1'b0, rail_enable_output});
    $display("test zero limit done");
    rail_below_uv = 8'h00;
    rail_cfg[5] = '{MODE_RETRYN, 4'h1, 1'b0, 12'h000};
    wr(8'h1B, 8'h00);
    rail_below_uv = 8'h20;
    n = 0;
    while (rail_enable_output[5] !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("retry n reasserted", 8'h01, {7'h00, rail_enable_output[5]});
    chk("retry n flagged", 8'h01, {7'h00, rail_fail[5]});
    rail_below_uv = 8'h00;
    fail_clear = 8'h20;
    @(negedge clk);
    fail_clear = 8'h00;
    @(negedge clk);
    wr(8'h1B, 8'h00);
    rail_below_uv = 8'h20;
    repeat (10) @(negedge clk);
    chk("retry n exhausted", 8'h02, {6'h00, rail_fail[5], rail_enable_output[5]});
    $display("test retry n done");
    rail_cfg[6] = '{MODE_LOG, 4'h0, 1'b0, 12'h000};
    wr(8'h1B, 8'hC0);
    rail_below_uv = 8'hC0;
    repeat (3) @(negedge clk);
    chk("log only flags", 8'h40, rail_fail & 8'hC0);
    chk("log keeps enables", 8'h41, {1'b0, rail_enable_output[6], 5'h00, shared_enable_output_pin});
    $display("test log only done");
    resetn = 1'b0;
    @(negedge clk);
    chk("fail after reset", 8'h00, rail_fail);
    chk("pins after reset", 8'h00, {shared_enable_output_pin, rail_enable_output});
    chk("gpo after reset", 8'h00, {5'h00, general_output});
    resetn = 1'b1;
    rail_below_uv = 8'h00;
    u_reoc_host_model.read_byte(8'h1B, v, ok);
    chk("high byte after reset", 8'h00, v);
    $display("test reset done");
    report_and_stop();
  end
endmodule : tb_reoc_top
